// ==== common/hbp_consts.svh ====
// host port constants: widths and reset values
// assumes inclusion by every design file that needs a number
//
// Overview of operation
// - eight-bit data path to the host
// - selectable split-bus or multiplexed-bus protocol
// - up to sixteen user register locations
// - control works after power-up in port mode
// - stays usable only if instantiated or kept
// - accept a strobe only while both selects are active
// - split write data sampled edge after strobe
// - split acknowledge with burst inhibit together
// - split read data valid at acknowledge edge
// - split acknowledge low exactly one cycle
// - mux write data sampled cycle after strobe
// - mux ready/recover low exactly one cycle
// - mux read data valid at ready edge
// - forward user interrupt independent of transfers
// - interrupt follows user request until withdrawn
// - host interrupt output is active low
// - wait states until user logic ends
`ifndef HBP_CONSTS_SVH
`define HBP_CONSTS_SVH
// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define HBP_DATA_W 8
`define HBP_ADDR_W 5
`define HBP_UADDR_W 4
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define HBP_DATA_RST 8'h00
`define HBP_ADDR_RST 5'h00
`define HBP_UADDR_RST 4'h0
`define HBP_BIT_RST 1'h0
`define HBP_PIN_IDLE 1'h1
`endif

// ==== common/hbp_pkg.sv ====
// host port types: link state machine and bus protocol choice
// assumes the constants header is available on the include path
package hbp_pkg;
  // link states, gray coded along idle-data-wait-ack
  typedef enum logic [1:0]
  {
    HBP_IDLE = 2'h0,
    HBP_DATA = 2'h1,
    HBP_WAIT = 2'h3,
    HBP_ACK = 2'h2
  } hbp_link_state_t;
  // protocol served by the port
  typedef enum logic
  {
    HBP_MODE_SPLIT = 1'h0,
    HBP_MODE_MUX = 1'h1
  } hbp_bus_mode_t;
endpackage : hbp_pkg

// ==== common/hbp_xfer_if.sv ====
// transfer carrier between link domain and system domain
// assumes words are held stable before their toggle flips
`include "hbp_consts.svh"
interface hbp_xfer_if;
  logic req_tgl;                        // flips once per request
  logic [`HBP_ADDR_W-1:0] addr;         // latched host address
  logic rd;                             // high for a host read
  logic [`HBP_DATA_W-1:0] wdata;        // sampled write data
  logic done_tgl;                       // flips once per completion
  logic [`HBP_DATA_W-1:0] rdata;        // read data from user logic
  // link end raises requests
  modport link
  (
    output req_tgl, addr, rd, wdata,
    input done_tgl, rdata
  );
  // user end answers them
  modport user
  (
    input req_tgl, addr, rd, wdata,
    output done_tgl, rdata
  );
endinterface : hbp_xfer_if

// ==== core/hbp_host_port.sv ====
// host processor port: link state machine on the host clock,
// user handshake on the system clock
// assumes host pins are synchronous to port_clock and straps are
// static levels; port_clock keeps running between transfers, as irq and reset cross on it
`include "hbp_consts.svh"
module hbp_host_port
(
  // system clocking
  input logic sys_clk,
  input logic sys_rst,
  input logic clk_en,
  // host link clock
  input logic port_clock,
  // host selects and strobes
  input logic select_low_active,
  input logic select_high_active,
  input logic port_strobe_n,
  input logic port_direction,
  input logic address_latch_enable,
  // host address, split mode pins and mux byte enables
  input logic [`HBP_ADDR_W-1:0] host_addr,
  input logic byte_enable_bit0,
  input logic byte_enable_bit1,
  // host data pins, three signals
  input logic [`HBP_DATA_W-1:0] data_in,
  output logic [`HBP_DATA_W-1:0] data_out,
  output logic data_oe,
  // host answers
  output logic port_ack_n,
  output logic port_burst_inhibit_n,
  output logic port_irq_n,
  // device straps
  input logic bus_mode,
  input logic port_mode_pins,
  input logic device_configured,
  input logic port_in_bitstream,
  input logic keep_port_after_config,
  // user logic
  output logic [`HBP_UADDR_W-1:0] user_addr,
  output logic user_read,
  output logic [`HBP_DATA_W-1:0] user_wdata,
  output logic user_start,
  input logic [`HBP_DATA_W-1:0] user_rdata,
  input logic user_end,
  input logic user_irq_n
);
  // ----------------------------------------------------------------
  // carrier and link-domain control
  // ----------------------------------------------------------------
  hbp_xfer_if xfer();

  logic [1:0] ctl_s;            // synchronised {clk_en, reset}
  logic link_rst;               // system reset seen on port_clock
  logic link_ce;                // clock enable seen on port_clock
  logic [5:0] strap_s;          // synchronised straps and irq
  logic done_s;                 // synchronised completion toggle
  logic mode_s, mpins_s, cfg_s, inbit_s, keep_s, irq_s;
  hbp_pkg::hbp_bus_mode_t mode; // protocol in force
  logic enabled;                // port may take part
  logic sel_ok;                 // both selects active

  // link state
  hbp_pkg::hbp_link_state_t state, next_state;
  logic [`HBP_ADDR_W-1:0] addr, next_addr;
  logic [`HBP_ADDR_W-1:0] mux_lat, next_mux_lat;
  logic [`HBP_DATA_W-1:0] wdata, next_wdata;
  logic [`HBP_DATA_W-1:0] next_dout;
  logic rd, next_rd;
  logic req_tgl, next_req_tgl;
  logic done_seen, next_done_seen;
  logic keep_lat, next_keep_lat;
  logic next_oe, next_ack_n, next_bi_n, next_irq_n;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // read sense differs between the two protocols
  function automatic logic host_is_read
  (
    input hbp_pkg::hbp_bus_mode_t m,
    input logic dir
  );
    host_is_read = (m == hbp_pkg::HBP_MODE_SPLIT) ? dir : ~dir;
  endfunction : host_is_read

  // address source per protocol
  function automatic logic [`HBP_ADDR_W-1:0] host_address
  (
    input hbp_pkg::hbp_bus_mode_t m,
    input logic [`HBP_ADDR_W-1:0] pins,
    input logic [`HBP_ADDR_W-1:0] lat,
    input logic be1,
    input logic be0
  );
    if (m == hbp_pkg::HBP_MODE_SPLIT)
    begin
      host_address = pins;
    end
    else
    begin
      host_address = {lat[`HBP_ADDR_W-1:2], be1, be0};
    end
  endfunction : host_address

  // ----------------------------------------------------------------
  // crossings into the link domain
  // ----------------------------------------------------------------
  // reset and enable sync never reset themselves
  hbp_sync #(.W(2)) u_ctl_sync
  (
    .clk(port_clock),
    .rst(1'b0),
    .ce(1'b1),
    .d({clk_en, sys_rst}),
    .q(ctl_s)
  );
  assign link_ce = ctl_s[1];
  assign link_rst = ctl_s[0];

  // straps and user interrupt are asynchronous levels; the irq
  // crosses inverted so the sync's zero reset reads as no request
  // and no false interrupt leaves the port after reset
  hbp_sync #(.W(6)) u_strap_sync
  (
    .clk(port_clock),
    .rst(link_rst),
    .ce(link_ce),
    .d({bus_mode, port_mode_pins, device_configured,
        port_in_bitstream, keep_port_after_config, ~user_irq_n}),
    .q(strap_s)
  );
  assign {mode_s, mpins_s, cfg_s, inbit_s, keep_s, irq_s} =
    {strap_s[5:1], ~strap_s[0]};
  assign mode = hbp_pkg::hbp_bus_mode_t'(mode_s);

  // completion toggle from the system domain
  hbp_sync #(.W(1)) u_done_sync
  (
    .clk(port_clock),
    .rst(link_rst),
    .ce(link_ce),
    .d(xfer.done_tgl),
    .q(done_s)
  );

  // ----------------------------------------------------------------
  // system-domain handshake
  // ----------------------------------------------------------------
  hbp_user_side u_user
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .xfer(xfer),
    .user_addr(user_addr),
    .user_read(user_read),
    .user_wdata(user_wdata),
    .user_start(user_start),
    .user_rdata(user_rdata),
    .user_end(user_end)
  );

  // request words held until the next toggle
  assign xfer.req_tgl = req_tgl;
  assign xfer.addr = addr;
  assign xfer.rd = rd;
  assign xfer.wdata = wdata;

  // ----------------------------------------------------------------
  // port enable
  // ----------------------------------------------------------------
  // before configuration the mode pins alone enable the port;
  // afterwards it needs the bitstream or the kept bit, which is
  // frozen at configuration so a late change has no effect
  assign enabled = mpins_s &&
                   (!cfg_s || inbit_s || keep_lat);
  // both selects decoded here, whatever the configuration
  assign sel_ok = !select_low_active && select_high_active;

  // ----------------------------------------------------------------
  // mux address latch, falling edge
  // ----------------------------------------------------------------
  // capture shared-bus address while latch enable is high
  always_comb
  begin
    next_mux_lat = mux_lat;
    if (link_rst)
    begin
      next_mux_lat = `HBP_ADDR_RST;
    end
    else if (link_ce && address_latch_enable)
    begin
      next_mux_lat = data_in[`HBP_ADDR_W-1:0];
    end
  end
  // registers only
  always_ff @(negedge port_clock)
  begin
    mux_lat <= next_mux_lat;
  end

  // ----------------------------------------------------------------
  // link state machine next values
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_addr = addr;
    next_rd = rd;
    next_wdata = wdata;
    next_req_tgl = req_tgl;
    next_done_seen = done_seen;
    next_keep_lat = keep_lat;
    next_dout = data_out;
    next_oe = data_oe;
    next_ack_n = port_ack_n;
    next_bi_n = port_burst_inhibit_n;
    next_irq_n = port_irq_n;
    if (link_rst)
    begin
      next_state = hbp_pkg::HBP_IDLE;
      next_addr = `HBP_ADDR_RST;
      next_rd = `HBP_BIT_RST;
      next_wdata = `HBP_DATA_RST;
      next_req_tgl = `HBP_BIT_RST;
      next_done_seen = `HBP_BIT_RST;
      next_keep_lat = `HBP_BIT_RST;
      next_dout = `HBP_DATA_RST;
      next_oe = `HBP_BIT_RST;
      next_ack_n = `HBP_PIN_IDLE;
      next_bi_n = `HBP_PIN_IDLE;
      next_irq_n = `HBP_PIN_IDLE;
    end
    else if (link_ce)
    begin
      // interrupt is a plain level, untouched by transfers
      next_irq_n = irq_s;
      // kept bit only counts when set before configuration
      if (!cfg_s)
      begin
        next_keep_lat = keep_s;
      end
      // answers fall back high after one cycle
      next_ack_n = `HBP_PIN_IDLE;
      next_bi_n = `HBP_PIN_IDLE;
      case (state)
        hbp_pkg::HBP_IDLE:
        begin
          // strobe with address and direction already set up
          if (enabled && sel_ok && !port_strobe_n)
          begin
            next_addr = host_address(mode, host_addr, mux_lat,
                                     byte_enable_bit1,
                                     byte_enable_bit0);
            next_rd = host_is_read(mode, port_direction);
            next_state = hbp_pkg::HBP_DATA;
          end
        end
        hbp_pkg::HBP_DATA:
        begin
          // edge after the strobe cycle carries write data
          next_wdata = data_in;
          next_req_tgl = ~req_tgl;
          next_oe = rd;
          next_state = hbp_pkg::HBP_WAIT;
        end
        hbp_pkg::HBP_WAIT:
        begin
          // wait states until the user end comes back
          if (done_s != done_seen)
          begin
            next_done_seen = done_s;
            next_dout = xfer.rdata;
            next_ack_n = 1'b0;
            // burst inhibit only exists on the split bus
            next_bi_n = (mode == hbp_pkg::HBP_MODE_MUX);
            next_state = hbp_pkg::HBP_ACK;
          end
        end
        hbp_pkg::HBP_ACK:
        begin
          // one ack cycle done, release the data pins
          next_oe = 1'b0;
          next_state = hbp_pkg::HBP_IDLE;
        end
        default:
        begin
          next_state = hbp_pkg::HBP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link registers, outputs straight from here
  // ----------------------------------------------------------------
  always_ff @(posedge port_clock)
  begin
    state <= next_state;
    addr <= next_addr;
    rd <= next_rd;
    wdata <= next_wdata;
    req_tgl <= next_req_tgl;
    done_seen <= next_done_seen;
    keep_lat <= next_keep_lat;
    data_out <= next_dout;
    data_oe <= next_oe;
    port_ack_n <= next_ack_n;
    port_burst_inhibit_n <= next_bi_n;
    port_irq_n <= next_irq_n;
  end
endmodule : hbp_host_port

// ==== core/hbp_sync.sv ====
// two-flop level synchroniser, any width
// assumes each bit is a level or a toggle, never a pulse
module hbp_sync #(parameter int W = 1)
(
  // clocking
  input logic clk,
  input logic rst,
  input logic ce,
  // levels
  input logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;       // first stage, read only by q
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;
  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb
  begin
    next_meta = meta;
    next_q = q;
    if (rst)
    begin
      next_meta = '0;
      next_q = '0;
    end
    else if (ce)
    begin
      next_meta = d;
      next_q = meta;
    end
  end
  // registers only
  always_ff @(posedge clk)
  begin
    meta <= next_meta;
    q <= next_q;
  end
endmodule : hbp_sync

// ==== core/hbp_user_side.sv ====
// system-domain end: turns link requests into user start/end
// assumes user_end arrives while user_start or after it
`include "hbp_consts.svh"
module hbp_user_side
(
  // clocking
  input logic sys_clk,
  input logic sys_rst,
  input logic clk_en,
  // carrier from the link domain
  hbp_xfer_if.user xfer,
  // user logic
  output logic [`HBP_UADDR_W-1:0] user_addr,
  output logic user_read,
  output logic [`HBP_DATA_W-1:0] user_wdata,
  output logic user_start,
  input logic [`HBP_DATA_W-1:0] user_rdata,
  input logic user_end
);
  logic req_s;                          // synchronised request toggle
  logic req_seen;                       // last toggle served
  logic busy;                           // user transfer open
  logic done_tgl;
  logic [`HBP_DATA_W-1:0] rdata;
  logic next_req_seen, next_busy, next_done_tgl, next_start, next_read;
  logic [`HBP_DATA_W-1:0] next_rdata, next_wdata;
  logic [`HBP_UADDR_W-1:0] next_addr;
  // toggle crossing into this domain
  hbp_sync #(.W(1)) u_req_sync
  (
    .clk(sys_clk),
    .rst(sys_rst),
    .ce(clk_en),
    .d(xfer.req_tgl),
    .q(req_s)
  );
  assign xfer.done_tgl = done_tgl;
  assign xfer.rdata = rdata;
  // ----------------------------------------------------------------
  // handshake next values
  // ----------------------------------------------------------------
  always_comb
  begin
    next_req_seen = req_seen;
    next_busy = busy;
    next_done_tgl = done_tgl;
    next_rdata = rdata;
    next_addr = user_addr;
    next_read = user_read;
    next_wdata = user_wdata;
    next_start = user_start;
    if (sys_rst)
    begin
      next_req_seen = `HBP_BIT_RST;
      next_busy = `HBP_BIT_RST;
      next_done_tgl = `HBP_BIT_RST;
      next_rdata = `HBP_DATA_RST;
      next_addr = `HBP_UADDR_RST;
      next_read = `HBP_BIT_RST;
      next_wdata = `HBP_DATA_RST;
      next_start = `HBP_BIT_RST;
    end
    else if (clk_en)
    begin
      next_start = 1'b0;
      // new request: words were stable before the toggle moved
      if (!busy && (req_s != req_seen))
      begin
        next_req_seen = req_s;
        next_addr = xfer.addr[`HBP_UADDR_W-1:0];
        next_read = xfer.rd;
        next_wdata = xfer.wdata;
        next_start = 1'b1;
        next_busy = 1'b1;
      end
      // completion: start wired to end is legal here
      else if (busy && user_end)
      begin
        next_rdata = user_rdata;
        next_done_tgl = ~done_tgl;
        next_busy = 1'b0;
      end
    end
  end
  // registers only
  always_ff @(posedge sys_clk)
  begin
    req_seen <= next_req_seen;
    busy <= next_busy;
    done_tgl <= next_done_tgl;
    rdata <= next_rdata;
    user_addr <= next_addr;
    user_read <= next_read;
    user_wdata <= next_wdata;
    user_start <= next_start;
  end
endmodule : hbp_user_side

// ==== verif/hbp_host_model.sv ====
// host processor model: one single-beat transfer per call
// assumes a free-running port_clock, as a system clock would be
`include "hbp_consts.svh"
module hbp_host_model
(
  // host clock
  input logic port_clock,
  // pins toward the port
  output logic select_low_active = 1'b1,
  output logic select_high_active = 1'b0,
  output logic port_strobe_n = 1'b1,
  output logic port_direction = 1'b0,
  output logic address_latch_enable = 1'b0,
  output logic [`HBP_ADDR_W-1:0] host_addr = 5'h00,
  output logic byte_enable_bit0 = 1'b0,
  output logic byte_enable_bit1 = 1'b0,
  // resolved data bus
  output logic [`HBP_DATA_W-1:0] data_in,
  input logic [`HBP_DATA_W-1:0] data_out,
  input logic data_oe,
  // answers
  input logic port_ack_n,
  input logic port_burst_inhibit_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [`HBP_DATA_W-1:0] hd = 8'h00; // last value put on the bus
  logic hdrv = 1'b0; // host drives the bus
  // released bus shows the inverse, so stale data cannot pass
  assign data_in = data_oe ? data_out : (hdrv ? hd : ~hd);
  // ------------------------------------------------------------
  // one transfer; mux puts the address on the shared bus
  // ------------------------------------------------------------
  task automatic xfer(input logic mux, rd, sel,
    input logic [`HBP_ADDR_W-1:0] a, input logic [`HBP_DATA_W-1:0] wd,
    output logic [`HBP_DATA_W-1:0] got, output logic ok, output logic bi);
    ok = 1'b0;
    @(posedge port_clock);
    select_low_active <= !sel;
    select_high_active <= sel;
    port_direction <= mux ? !rd : rd;
    port_strobe_n <= 1'b0;
    host_addr <= mux ? ~a : a; // mux mode must ignore these
    byte_enable_bit0 <= a[0];
    byte_enable_bit1 <= a[1];
    address_latch_enable <= mux;
    hd <= {3'h0, a[4:2], ~a[1:0]};
    hdrv <= mux;
    @(posedge port_clock);
    // strobe taken; data phase until the answer
    port_strobe_n <= 1'b1;
    address_latch_enable <= 1'b0;
    hd <= wd;
    hdrv <= !rd;
    for (int n = 0; n < 300 && !ok; n++)
    begin
      @(posedge port_clock);
      ok = (port_ack_n === 1'b0);
    end
    got = data_in;
    bi = (port_burst_inhibit_n === 1'b0);
    select_low_active <= 1'b1;
    select_high_active <= 1'b0;
    hdrv <= 1'b0;
  endtask : xfer
endmodule : hbp_host_model

// ==== verif/hbp_monitor.sv ====
// checker for the host port: ack pulse, burst inhibit, irq, oe
// assumes straps only change while no transfer is open
module hbp_monitor
(
  // clocks and reset
  input logic sys_clk,
  input logic sys_rst,
  input logic port_clock,
  // host pins
  input logic select_low_active,
  input logic select_high_active,
  input logic port_strobe_n,
  input logic data_oe,
  input logic port_ack_n,
  input logic port_burst_inhibit_n,
  input logic port_irq_n,
  // straps
  input logic bus_mode,
  input logic port_mode_pins,
  input logic device_configured,
  input logic port_in_bitstream,
  input logic keep_port_after_config,
  // user side
  input logic user_start,
  input logic user_end,
  input logic user_irq_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------
  logic keep_seen; // keep bit as latched before configuration
  logic pend; // strobe taken, ack still owed
  logic ended; // user end seen since the strobe
  logic take; // strobe the port must accept
  assign take = port_mode_pins && !select_low_active
    && select_high_active && !port_strobe_n && !pend
    && (!device_configured || port_in_bitstream || keep_seen);
  // keep only follows the pin while unconfigured
  always_ff @(posedge sys_clk)
    if (!device_configured)
      keep_seen <= keep_port_after_config;
  // open transfer on the host clock
  always_ff @(posedge port_clock)
    if (sys_rst || !port_ack_n)
      pend <= 1'b0;
    else if (take)
      pend <= 1'b1;
  // a stale end from the last transfer only weakens this, never misfires
  always_ff @(posedge port_clock)
    if (sys_rst || take)
      ended <= 1'b0;
    else if (user_end)
      ended <= 1'b1;
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  ack_pulse_a: assert property (
    @(posedge port_clock) disable iff (sys_rst)
    $fell(port_ack_n) |=> port_ack_n)
    else $error("ack low longer than one cycle");
  ack_cause_a: assert property (
    @(posedge port_clock) disable iff (sys_rst)
    $fell(port_ack_n) |-> pend && ended)
    else $error("ack without strobe or user end");
  start_bound_a: assert property (
    @(posedge port_clock) disable iff (sys_rst)
    take |-> ##[1:24] user_start)
    else $error("accepted strobe gave no user start");
  bi_pair_a: assert property (
    @(posedge port_clock) disable iff (sys_rst)
    !port_ack_n && !bus_mode |-> !port_burst_inhibit_n)
    else $error("split ack without burst inhibit");
  bi_idle_a: assert property (
    @(posedge port_clock) disable iff (sys_rst)
    port_ack_n |-> port_burst_inhibit_n)
    else $error("burst inhibit low outside ack");
  bi_mux_a: assert property (
    @(posedge port_clock) disable iff (sys_rst)
    bus_mode |-> port_burst_inhibit_n)
    else $error("burst inhibit low in mux mode");
  oe_end_a: assert property (
    @(posedge port_clock) disable iff (sys_rst)
    $fell(data_oe) |-> !$past(port_ack_n))
    else $error("data drive ended away from ack");
  irq_high_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    user_irq_n [*8] |-> port_irq_n)
    else $error("irq held after user withdrew");
  irq_low_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !user_irq_n [*8] |-> !port_irq_n)
    else $error("user irq not forwarded low");
  irq_spur_a: assert property (
    @(posedge port_clock) disable iff (sys_rst)
    $fell(port_irq_n) |-> !$past(user_irq_n, 3))
    else $error("irq raised with no user request");
endmodule : hbp_monitor
bind hbp_host_port hbp_monitor i_hbp_monitor (.*);

// ==== verif/tb_hbp_host_port.sv ====
// testbench for the host port: straps, host transfers, irq
// assumes the host model and the checker are compiled before it
`include "hbp_consts.svh"
module tb_hbp_host_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1; // freeze is not exercised
  logic port_clock = 1'b0;
  logic bus_mode = 1'b0;
  logic port_mode_pins = 1'b1;
  logic device_configured = 1'b0;
  logic port_in_bitstream = 1'b0;
  logic keep_port_after_config = 1'b0;
  logic [`HBP_DATA_W-1:0] user_rdata = 8'h00;
  logic user_end = 1'b0;
  logic user_irq_n = 1'b1;
  // host pins, driven by the model
  logic select_low_active, select_high_active, port_strobe_n;
  logic port_direction, address_latch_enable;
  logic byte_enable_bit0, byte_enable_bit1;
  logic [`HBP_ADDR_W-1:0] host_addr;
  logic [`HBP_DATA_W-1:0] data_in, data_out, user_wdata, got;
  logic data_oe, port_ack_n, port_burst_inhibit_n, port_irq_n;
  logic [`HBP_UADDR_W-1:0] user_addr;
  logic user_read, user_start, ok, bi, busy = 1'b0;
  int n_fail = 0, checks_done = 0, n_start = 0, dly = 0, wcnt = 0;
  hbp_host_port i_hbp_host_port (.*);
  hbp_host_model i_hbp_host_model (.*);
  // system clock 40 ns; link clock 15 ns, rising edges never meet
  always #20 sys_clk = ~sys_clk;
  always #7.5 port_clock = ~port_clock;
  // user logic: count starts, end after dly cycles
  always @(posedge sys_clk)
  begin
    if (user_start === 1'b1)
    begin
      n_start++;
      busy = 1'b1;
      wcnt = dly;
    end
    user_end <= (busy && wcnt == 0);
    if (busy)
      busy = (wcnt != 0);
    if (wcnt != 0)
      wcnt--;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic strap(input logic m, p, c, b, k);
    @(posedge sys_clk);
    bus_mode <= m;
    port_mode_pins <= p;
    device_configured <= c;
    port_in_bitstream <= b;
    keep_port_after_config <= k;
    repeat (10) @(posedge sys_clk);
  endtask : strap
  // one transfer; want says whether the port must answer
  task automatic run(input logic mux, rd, sel, input logic [4:0] a,
    input logic [7:0] wd, rv, input int d, input logic want);
    int s0;
    s0 = n_start;
    @(posedge sys_clk);
    user_rdata <= rv;
    dly = d;
    i_hbp_host_model.xfer(mux, rd, sel, a, wd, got, ok, bi);
    chk("ack seen", {7'h0, ok}, {7'h0, want});
    chk("start count", 8'(n_start - s0), {7'h0, want});
    if (want && !ok)
      complete_run();
  endtask : run
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic sc_split();
    run(1'b0, 1'b0, 1'b1, 5'h13, 8'h3c, 8'h00, 0, 1'b1);
    chk("split waddr", {4'h0, user_addr}, 8'h03);
    chk("split dir", {7'h0, user_read}, 8'h00);
    chk("split wdata", user_wdata, 8'h3c);
    chk("split bi", {7'h0, bi}, 8'h01);
    run(1'b0, 1'b1, 1'b1, 5'h0e, 8'h00, 8'ha5, 6, 1'b1);
    chk("split rdata", got, 8'ha5);
    chk("split raddr", {4'h0, user_addr}, 8'h0e);
    chk("split rdir", {7'h0, user_read}, 8'h01);
    run(1'b0, 1'b0, 1'b1, 5'h01, 8'h81, 8'h00, 0, 1'b1);
    chk("split next", user_wdata, 8'h81);
  endtask : sc_split
  task automatic sc_mux();
    strap(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    run(1'b1, 1'b0, 1'b1, 5'h0b, 8'h5a, 8'h00, 2, 1'b1);
    chk("mux waddr", {4'h0, user_addr}, 8'h0b);
    chk("mux dir", {7'h0, user_read}, 8'h00);
    chk("mux wdata", user_wdata, 8'h5a);
    chk("mux bi", {7'h0, bi}, 8'h00);
    run(1'b1, 1'b1, 1'b1, 5'h16, 8'h00, 8'h69, 3, 1'b1);
    chk("mux rdata", got, 8'h69);
    chk("mux raddr", {4'h0, user_addr}, 8'h06);
    strap(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
  endtask : sc_mux
  // mode pins, configuration and keep decide if the port answers
  task automatic sc_enable();
    strap(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    run(1'b0, 1'b0, 1'b1, 5'h04, 8'h11, 8'h00, 0, 1'b0);
    strap(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    run(1'b0, 1'b0, 1'b1, 5'h04, 8'h12, 8'h00, 0, 1'b0);
    strap(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    run(1'b0, 1'b0, 1'b1, 5'h04, 8'h13, 8'h00, 0, 1'b1);
    strap(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    strap(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    run(1'b0, 1'b0, 1'b1, 5'h04, 8'h14, 8'h00, 0, 1'b1);
    run(1'b0, 1'b0, 1'b0, 5'h04, 8'h15, 8'h00, 0, 1'b0);
  endtask : sc_enable
  task automatic sc_irq();
    @(posedge sys_clk);
    user_irq_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk("irq on", {7'h0, port_irq_n}, 8'h00);
    run(1'b0, 1'b1, 1'b1, 5'h02, 8'h00, 8'h24, 1, 1'b1);
    chk("irq held", {7'h0, port_irq_n}, 8'h00);
    @(posedge sys_clk);
    user_irq_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk("irq off", {7'h0, port_irq_n}, 8'h01);
  endtask : sc_irq
  // main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    chk("idle ack", {7'h0, port_ack_n}, 8'h01);
    chk("idle oe", {7'h0, data_oe}, 8'h00);
    repeat (10) @(posedge sys_clk);
    sc_split();
    sc_mux();
    sc_enable();
    sc_irq();
    complete_run();
  end
endmodule : tb_hbp_host_port
